// >>> core/pwcp_pkg.sv
package pwcp_pkg;
  // Clock rate
  localparam int CLK_HZ = 20000000;
  // Symbol and interval times in ns
  localparam int ZERO_NOM_NS = 1000;
  localparam int ONE_NOM_NS = 3000;
  localparam int RESET_INT_NS = 20000;
  localparam int LOAD_BASE_FREQUENCY_CMD_DLY_NS = 10000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  // Acceptance windows, +/-10 percent
  localparam int ZERO_MIN_CYC = (ZERO_NOM_NS * 9 + 10 * CLK_NS - 1) / (10 * CLK_NS);
  localparam int ZERO_MAX_CYC = (ZERO_NOM_NS * 11) / (10 * CLK_NS);
  localparam int ONE_MIN_CYC = (ONE_NOM_NS * 9 + 10 * CLK_NS - 1) / (10 * CLK_NS);
  localparam int ONE_MAX_CYC = (ONE_NOM_NS * 11) / (10 * CLK_NS);
  localparam int RESET_CYC = (RESET_INT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_BASE_FREQUENCY_CMD_CYC = LOAD_BASE_FREQUENCY_CMD_DLY_NS / CLK_NS;
  localparam int CNT_W = 12;
  // Frame layout
  localparam int FRAME_BITS = 15;
  localparam int PRE_BITS = 7;
  localparam int BYTE_BITS = 8;
  // Command codes
  localparam logic [7:0] CMD_RUN = 8'h50;
  localparam logic [7:0] CMD_STOP = 8'h18;
  localparam logic [7:0] CMD_DOZE = 8'h20;
  localparam logic [7:0] CMD_SLEEP = 8'h30;
  localparam logic [7:0] CMD_LOAD_BASE_FREQUENCY_CMD = 8'h0c;
  localparam logic [2:0] LOAD_BASE_FREQUENCY_CMD_ARGS = 3'h4;
  // Default base frequency, arbitrary neutral value
  localparam logic [31:0] BASE_FREQ_RST = 32'h4b189680;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_SETUP = 3'h1,
    MODE_STOP = 3'h3,
    MODE_DOZE = 3'h2,
    MODE_SLEEP = 3'h6
  } pwcp_mode_type;
  // Link states
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_READY = 2'h1,
    LINK_LOCKED = 2'h3
  } pwcp_link_type;
endpackage

// >>> core/pwcp_top.sv
`timescale 1ns/100ps
module pwcp_top
  import pwcp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SINGLE_WIRE_DATA_I,
  output logic [7:0] CMD_DATA_O,
  output logic CMD_VALID_O,
  input wire logic CMD_READY_I,
  output logic [2:0] MODE_O,
  output logic OUT_ENABLE_O,
  output logic POWER_SAVE_O,
  output logic CORE_POWER_O,
  output logic [31:0] BASE_FREQ_O,
  output logic [15:0] OFFSET_O,
  output logic LINK_READY_O
);
  logic sync1_r;
  logic sync2_r;
  logic wire_prev_r;
  logic [CNT_W-1:0] width_cnt_r;
  logic steady_hit_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic frame_bad_r;
  logic byte_stb;
  logic [7:0] byte_val;
  logic edge_seen;
  logic gap_seen;
  logic bit_edge;
  logic is_zero;
  logic is_one;
  logic sym_ok;
  logic last_bit;
  pwcp_link_type link_r;
  pwcp_mode_type mode_r;
  logic [7:0] cmd_r;
  logic [2:0] args_left_r;
  logic [31:0] freq_acc_r;
  logic [31:0] base_freq_r;
  logic [31:0] pend_val_r;
  logic [31:0] new_freq;
  logic [15:0] offset_r;
  logic pend_freq_r;
  logic [CNT_W-1:0] blank_cnt_r;
  logic exec_stb;
  logic [7:0] exec_cmd;
  logic freq_done;
  logic freq_live;
  logic simple_cmd;
  logic resume_cmd;
  logic [7:0] buf_data_r [2];
  logic [1:0] buf_cnt_r;
  logic buf_wp_r;
  logic buf_rp_r;
  logic buf_in_rdy;
  logic buf_push;
  logic buf_pop;

  // Two-stage input synchroniser
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      wire_prev_r <= 1'b1;
    end else begin
      sync1_r <= SINGLE_WIRE_DATA_I;
      sync2_r <= sync1_r;
      wire_prev_r <= sync2_r;
    end
  end

  // Edge detector idles at the pulled-up level of the pin
  assign edge_seen = sync2_r != wire_prev_r;
  // A pause longer than any symbol opens a new frame
  assign gap_seen = width_cnt_r > CNT_W'(ONE_MAX_CYC);
  assign bit_edge = edge_seen && !gap_seen;
  assign is_zero = width_cnt_r >= CNT_W'(ZERO_MIN_CYC) && width_cnt_r <= CNT_W'(ZERO_MAX_CYC);
  assign is_one = width_cnt_r >= CNT_W'(ONE_MIN_CYC) && width_cnt_r <= CNT_W'(ONE_MAX_CYC);
  assign sym_ok = is_zero || is_one;
  assign last_bit = bit_cnt_r == 4'(FRAME_BITS - 1);

  // Width of the current level in cycles
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      width_cnt_r <= '0;
    end else if (edge_seen) begin
      width_cnt_r <= CNT_W'(1);
    end else if (width_cnt_r < CNT_W'(RESET_CYC)) begin
      width_cnt_r <= width_cnt_r + CNT_W'(1);
    end
  end

  // One pulse once the level has stood for the reset interval
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || edge_seen) begin
      steady_hit_r <= 1'b0;
    end else begin
      steady_hit_r <= width_cnt_r == CNT_W'(RESET_CYC - 1);
    end
  end

  // Position within the frame
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || steady_hit_r) begin
      bit_cnt_r <= '0;
    end else if (edge_seen && gap_seen) begin
      bit_cnt_r <= '0;
    end else if (bit_edge) begin
      if (last_bit) begin
        bit_cnt_r <= '0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // Bad width or a one in the preamble spoils the frame
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || steady_hit_r) begin
      frame_bad_r <= 1'b0;
    end else if (edge_seen && gap_seen) begin
      frame_bad_r <= 1'b0;
    end else if (bit_edge) begin
      if (last_bit) begin
        frame_bad_r <= 1'b0;
      end else if (!sym_ok) begin
        frame_bad_r <= 1'b1;
      end else if (bit_cnt_r < 4'(PRE_BITS) && is_one) begin
        frame_bad_r <= 1'b1;
      end
    end
  end

  // Byte field, least significant bit first
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || steady_hit_r) begin
      shift_r <= '0;
    end else if (bit_edge && bit_cnt_r >= 4'(PRE_BITS)) begin
      shift_r <= {is_one, shift_r[7:1]};
    end
  end

  assign byte_stb = bit_edge && last_bit && !frame_bad_r && sym_ok;
  assign byte_val = {is_one, shift_r[7:1]};

  // Link readiness: a steady interval arms it after reset or wake
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      link_r <= LINK_IDLE;
    end else if (mode_r == MODE_SLEEP) begin
      link_r <= LINK_LOCKED;
    end else begin
      case (link_r)
        LINK_IDLE: begin
          if (steady_hit_r) begin
            link_r <= LINK_READY;
          end
        end
        LINK_READY: begin
          link_r <= LINK_READY;
        end
        LINK_LOCKED: begin
          if (steady_hit_r) begin
            link_r <= LINK_READY;
          end
        end
        default: begin
          link_r <= LINK_IDLE;
        end
      endcase
    end
  end

  assign exec_stb = byte_stb && link_r == LINK_READY && mode_r != MODE_SLEEP;
  assign exec_cmd = byte_val;

  // Command byte and argument assembly
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || steady_hit_r) begin
      args_left_r <= '0;
      cmd_r <= '0;
      freq_acc_r <= '0;
    end else if (exec_stb) begin
      if (args_left_r != 3'h0) begin
        freq_acc_r <= {freq_acc_r[23:0], byte_val};
        args_left_r <= args_left_r - 3'h1;
      end else if (byte_val == CMD_LOAD_BASE_FREQUENCY_CMD) begin
        cmd_r <= byte_val;
        args_left_r <= LOAD_BASE_FREQUENCY_CMD_ARGS;
      end else begin
        cmd_r <= byte_val;
        args_left_r <= 3'h0;
      end
    end
  end

  assign new_freq = {freq_acc_r[23:0], byte_val};
  assign freq_done = exec_stb && args_left_r == 3'h1 && cmd_r == CMD_LOAD_BASE_FREQUENCY_CMD;
  assign freq_live = mode_r == MODE_RUN || mode_r == MODE_SETUP;
  assign simple_cmd = exec_stb && args_left_r == 3'h0 && byte_val != CMD_LOAD_BASE_FREQUENCY_CMD;
  assign resume_cmd = simple_cmd && exec_cmd == CMD_RUN;

  // Mode controller
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode_r <= MODE_RUN;
    end else begin
      case (mode_r)
        MODE_SLEEP: begin
          if (edge_seen) begin
            mode_r <= MODE_RUN;
          end
        end
        MODE_SETUP: begin
          if (blank_cnt_r == '0) begin
            mode_r <= MODE_RUN;
          end
        end
        MODE_RUN: begin
          if (freq_done) begin
            mode_r <= MODE_SETUP;
          end else if (simple_cmd && exec_cmd == CMD_STOP) begin
            mode_r <= MODE_STOP;
          end else if (simple_cmd && exec_cmd == CMD_DOZE) begin
            mode_r <= MODE_DOZE;
          end else if (simple_cmd && exec_cmd == CMD_SLEEP) begin
            mode_r <= MODE_SLEEP;
          end
        end
        MODE_STOP, MODE_DOZE: begin
          if (resume_cmd) begin
            mode_r <= MODE_RUN;
          end
        end
        default: begin
          mode_r <= MODE_RUN;
        end
      endcase
    end
  end

  // Base frequency: applied at once while live, else on resume
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      base_freq_r <= BASE_FREQ_RST;
    end else if (freq_done && freq_live) begin
      base_freq_r <= new_freq;
    end else if (resume_cmd && pend_freq_r) begin
      base_freq_r <= pend_val_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      offset_r <= OFFSET_RST;
    end else if (freq_done) begin
      offset_r <= OFFSET_RST;
    end
  end

  // Latest value written while the output is off wins
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pend_freq_r <= 1'b0;
      pend_val_r <= BASE_FREQ_RST;
    end else if (freq_done && !freq_live) begin
      pend_freq_r <= 1'b1;
      pend_val_r <= new_freq;
    end else if (resume_cmd) begin
      pend_freq_r <= 1'b0;
    end
  end

  // Output blanking after a reload applied while live
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      blank_cnt_r <= '0;
    end else if (freq_done && freq_live) begin
      blank_cnt_r <= CNT_W'(LOAD_BASE_FREQUENCY_CMD_CYC);
    end else if (mode_r == MODE_SETUP && blank_cnt_r != '0) begin
      blank_cnt_r <= blank_cnt_r - CNT_W'(1);
    end
  end

  // Two-entry buffer of executed no-argument commands
  assign buf_in_rdy = buf_cnt_r != 2'h2;
  assign buf_push = simple_cmd && buf_in_rdy;
  assign buf_pop = CMD_VALID_O && CMD_READY_I;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      buf_data_r[0] <= '0;
      buf_data_r[1] <= '0;
    end else if (buf_push) begin
      buf_data_r[buf_wp_r] <= exec_cmd;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      buf_cnt_r <= '0;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_wp_r <= !buf_wp_r;
      end
      if (buf_pop) begin
        buf_rp_r <= !buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r + 2'(buf_push ? 1 : 0) - 2'(buf_pop ? 1 : 0);
    end
  end

  assign CMD_VALID_O = buf_cnt_r != 2'h0;
  assign CMD_DATA_O = buf_data_r[buf_rp_r];
  assign MODE_O = mode_r;
  assign OUT_ENABLE_O = mode_r == MODE_RUN;
  assign POWER_SAVE_O = mode_r == MODE_DOZE || mode_r == MODE_SLEEP;
  assign CORE_POWER_O = mode_r != MODE_SLEEP;
  assign BASE_FREQ_O = base_freq_r;
  assign OFFSET_O = offset_r;
  assign LINK_READY_O = link_r == LINK_READY;
endmodule

// >>> verification/pwcp_host_model.sv
`timescale 1ns/100ps
module pwcp_host_model
  import pwcp_pkg::*;
(
  input wire logic clk_i,
  output logic wire_o
);
  initial wire_o = 1'b1;
  task automatic hold(input int cyc);
    repeat (cyc) @(posedge clk_i);
  endtask
  // Steady level past the reset interval
  task automatic setup_seq();
    hold(RESET_CYC + 20);
  endtask
  task automatic send_byte(input logic [7:0] val);
    logic [14:0] frame;
    frame = {val, 7'h00};
    @(posedge clk_i);
    wire_o <= ~wire_o;
    for (int i = 0; i < FRAME_BITS; i++) begin
      hold(frame[i] ? ONE_NOM_NS / CLK_NS : ZERO_NOM_NS / CLK_NS);
      wire_o <= ~wire_o;
    end
    hold(100);
  endtask
endmodule

// >>> verification/pwcp_top_chk.sv
`timescale 1ns/100ps
module pwcp_top_chk
  import pwcp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SINGLE_WIRE_DATA_I,
  input wire logic [7:0] CMD_DATA_O,
  input wire logic CMD_VALID_O,
  input wire logic CMD_READY_I,
  input wire logic [2:0] MODE_O,
  input wire logic OUT_ENABLE_O,
  input wire logic POWER_SAVE_O,
  input wire logic CORE_POWER_O,
  input wire logic [31:0] BASE_FREQ_O,
  input wire logic [15:0] OFFSET_O,
  input wire logic LINK_READY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [9:0] calm_r;
  logic wire_d_r;
  always_ff @(posedge CLK_I) begin
    wire_d_r <= SINGLE_WIRE_DATA_I;
    if (SYS_RST_I || wire_d_r != SINGLE_WIRE_DATA_I) begin
      calm_r <= 10'h000;
    end else if (calm_r != 10'h3ff) begin
      calm_r <= calm_r + 10'h001;
    end
  end
  sequence s_enter_setup;
    $changed(MODE_O) && MODE_O == MODE_SETUP;
  endsequence
  property p_setup_src;
    s_enter_setup |-> $past(MODE_O) == MODE_RUN;
  endproperty
  a_setup_src: assert property (p_setup_src) else $error("setup src");
  property p_restart;
    s_enter_setup |-> ##[1:220] MODE_O == MODE_RUN;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_offset_clr;
    $changed(BASE_FREQ_O) |-> OFFSET_O == OFFSET_RST;
  endproperty
  a_offset_clr: assert property (p_offset_clr) else $error("offset kept");
  property p_sleep_hold;
    MODE_O == MODE_SLEEP |=> $stable(BASE_FREQ_O);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep write");
  property p_sleep_pwr;
    (MODE_O == MODE_SLEEP)[*2] |-> !CORE_POWER_O && POWER_SAVE_O && !OUT_ENABLE_O;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep power");
  property p_doze_pwr;
    (MODE_O == MODE_DOZE)[*2] |-> CORE_POWER_O && POWER_SAVE_O && !OUT_ENABLE_O;
  endproperty
  a_doze_pwr: assert property (p_doze_pwr) else $error("doze power");
  property p_run_pwr;
    (MODE_O == MODE_RUN)[*2] |-> CORE_POWER_O && !POWER_SAVE_O && OUT_ENABLE_O;
  endproperty
  a_run_pwr: assert property (p_run_pwr) else $error("run power");
  property p_link_calm;
    $rose(LINK_READY_O) |-> calm_r >= 10'h17c;
  endproperty
  a_link_calm: assert property (p_link_calm) else $error("early link");
  property p_valid_hold;
    CMD_VALID_O && !CMD_READY_I |=> CMD_VALID_O && $stable(CMD_DATA_O);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("word lost");
endmodule
bind pwcp_top pwcp_top_chk u_chk(.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .SINGLE_WIRE_DATA_I(SINGLE_WIRE_DATA_I), .CMD_DATA_O(CMD_DATA_O),
  .CMD_VALID_O(CMD_VALID_O), .CMD_READY_I(CMD_READY_I), .MODE_O(MODE_O),
  .OUT_ENABLE_O(OUT_ENABLE_O), .POWER_SAVE_O(POWER_SAVE_O), .CORE_POWER_O(CORE_POWER_O),
  .BASE_FREQ_O(BASE_FREQ_O), .OFFSET_O(OFFSET_O), .LINK_READY_O(LINK_READY_O));

// >>> verification/test_pulse_width_command_port.sv
`timescale 1ns/100ps
module test_pulse_width_command_port
  import pwcp_pkg::*;
;
  logic clk, rst, ready, wire_d, valid, oe, psave, cpwr, link;
  logic [7:0] cmd_data;
  logic [2:0] mode;
  logic [31:0] base;
  logic [15:0] offs;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  pwcp_top dut(.CLK_I(clk), .SYS_RST_I(rst), .SINGLE_WIRE_DATA_I(wire_d),
    .CMD_DATA_O(cmd_data), .CMD_VALID_O(valid), .CMD_READY_I(ready), .MODE_O(mode),
    .OUT_ENABLE_O(oe), .POWER_SAVE_O(psave), .CORE_POWER_O(cpwr), .BASE_FREQ_O(base),
    .OFFSET_O(offs), .LINK_READY_O(link));
  pwcp_host_model host(.clk_i(clk), .wire_o(wire_d));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    #1;
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic nf(input logic [31:0] w, input int n);
    host.send_byte(CMD_LOAD_BASE_FREQUENCY_CMD);
    for (int i = 3; i > 3 - n; i--) host.send_byte(w[i*8 +: 8]);
  endtask
  task automatic pop(input logic [7:0] exp);
    check(cmd_data, exp);
    @(posedge clk);
    ready <= 1'b1;
    @(posedge clk);
    ready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_modes();
    @(posedge clk);
    ready <= 1'b0;
    host.send_byte(CMD_STOP);
    check(mode, MODE_STOP);
    check(oe, 1'b0);
    host.send_byte(CMD_DOZE);
    check(mode, MODE_STOP);
    host.send_byte(CMD_RUN);
    check(mode, MODE_RUN);
    pop(CMD_STOP);
    pop(CMD_DOZE);
    check(valid, 1'b0);
    @(posedge clk);
    ready <= 1'b1;
    host.send_byte(CMD_DOZE);
    check(mode, MODE_DOZE);
    check(psave, 1'b1);
    host.send_byte(CMD_RUN);
    check(mode, MODE_RUN);
    $display("Test modes done");
  endtask
  task automatic t_freq();
    nf(32'h4a742400, 4);
    check(mode, MODE_SETUP);
    repeat (LOAD_BASE_FREQUENCY_CMD_CYC) @(posedge clk);
    check(mode, MODE_RUN);
    check(base, 32'h4a742400);
    check(offs, OFFSET_RST);
    host.send_byte(CMD_STOP);
    nf(32'h47000000, 4);
    nf(32'h4c3ebc20, 4);
    check(mode, MODE_STOP);
    check(base, 32'h4a742400);
    host.send_byte(CMD_RUN);
    repeat (LOAD_BASE_FREQUENCY_CMD_CYC) @(posedge clk);
    check(base, 32'h4c3ebc20);
    nf(32'h4a742400, 3);
    check(base, 32'h4c3ebc20);
    host.setup_seq();
    host.send_byte(8'h00);
    check(base, 32'h4c3ebc20);
    host.send_byte(8'h77);
    check(mode, MODE_RUN);
    $display("Test frequency done");
  endtask
  task automatic t_sleep();
    host.send_byte(CMD_SLEEP);
    check(mode, MODE_SLEEP);
    check(cpwr, 1'b0);
    host.send_byte(CMD_STOP);
    check(mode == MODE_STOP, 1'b0);
    check(mode, MODE_RUN);
    check(link, 1'b0);
    host.setup_seq();
    check(link, 1'b1);
    host.send_byte(CMD_STOP);
    check(mode, MODE_STOP);
    host.send_byte(CMD_RUN);
    check(mode, MODE_RUN);
    $display("Test sleep done");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    ready = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check(base, BASE_FREQ_RST);
    check(link, 1'b0);
    host.setup_seq();
    check(link, 1'b1);
    t_modes();
    t_freq();
    t_sleep();
    complete_run();
  end
endmodule
